// *** common/wit_map.vh ***
// register map, reset values and timing constants of the weak-infeed trip block
`ifndef WIT_MAP_VH
`define WIT_MAP_VH
// register byte offsets
`define WIT_A_CTRL      8'h00
`define WIT_A_RATIO     8'h04
`define WIT_A_TAU       8'h08
`define WIT_A_OPENPOLE  8'h0C
`define WIT_A_RESLVL    8'h10
`define WIT_A_RXEXT     8'h14
`define WIT_A_RESEXT    8'h18
`define WIT_A_RESALM    8'h1C
`define WIT_A_SPDLY     8'h20
`define WIT_A_MPDLY     8'h24
`define WIT_A_STATUS    8'h28
`define WIT_A_LATCH     8'h2C
// control field positions
`define WIT_F_MODE_LO   0
`define WIT_F_MODE_HI   1
`define WIT_F_SHARED    2
`define WIT_F_INST      3
`define WIT_F_TSEL_LO   4
`define WIT_F_TSEL_HI   5
`define WIT_F_SP_ALLOW  6
`define WIT_F_SP_RES    7
`define WIT_F_TP_ALLOW  8
// function and timed stage encodings
`define WIT_MODE_OFF    2'h0
`define WIT_MODE_ECHO   2'h1
`define WIT_MODE_TRIP   2'h2
`define WIT_TSEL_OFF    2'h0
`define WIT_TSEL_ON     2'h1
`define WIT_TSEL_RXFAIL 2'h2
// reset values
`define WIT_RST_CTRL    9'h1C9
`define WIT_RST_RATIO   7'h46
`define WIT_RATIO_MIN   7'h0A
`define WIT_RATIO_MAX   7'h64
`define WIT_RATIO_DIV   23'h000064
`define WIT_RST_TAU     6'h05
`define WIT_TAU_MIN     6'h01
`define WIT_TAU_MAX     6'h3C
`define WIT_RST_OPEN    16'h0100
`define WIT_RST_RESLVL  16'h0200
`define WIT_RST_RXEXT   16'h028A
`define WIT_RST_RESEXT  16'h0258
`define WIT_RST_RESALM  16'h2710
`define WIT_RST_SPDLY   16'h0190
`define WIT_RST_MPDLY   16'h03E8
`define WIT_INF         16'hFFFF
// timing
`define WIT_CLK_HZ      50000000
`define WIT_TICK_US     1000
`define WIT_TICK_CYC    (`WIT_CLK_HZ / 1000000 * `WIT_TICK_US)
`define WIT_RES3P_MS    16'h01F4
`define WIT_FILT_SHIFT  10
`endif

// *** core/wit_trip.v ***
// weak-infeed trip decision logic with apb settings and status
// Function
// - shared channel echo on: one merged echo, earth-fault echo suppressed; default off
// - undervoltage threshold is ratio 0.10..1.00 times phase-phase voltage, default 0.70
// - threshold follows phase-phase voltage through a slow lag, constant default 5 s
// - no undervoltage in a phase whose phase-phase voltage is below open-pole level
// - instant trip when receive and undervoltage are present together
// - other protection pickup blocks the matching weak-infeed phases
// - receive signal stretched by a settable time, default 0.65 s
// - overcurrent pickup in a phase latches out later pickup in that phase
// - receive, no undervoltage, residual over threshold beyond 500 ms gives three-pole trip
// - residual-exceeded indication held by a settable time, default 0.60 s
// - residual above threshold beyond alarm delay, default 10 s, raises alarm
// - instant stage works only while channel-healthy input is active
// - phase block inputs stop pickup and trip of the instant stage
// - instant stage switched on or off by a setting, default on
// - timed single-pole trip only when single-pole permission is on
// - residual qualification on requires residual exceeded for timed single-pole trip
// - three-pole permission off: multi-pole pickup reported only, single-pole still possible
// - timed stage picks up per phase; single delay 0.40 s, multi delay 1.00 s
// - timed stage on, off (default) or active on channel failure
// - fuse failure or voltage transformer breaker blocks undervoltage selection
// - function mode off, echo only (default) or echo and trip
// - timed stage block input inhibits the timed stage
// - general block input blocks all tripping
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "wit_map.vh"
module wit_trip #(
  parameter TICK_CYC = `WIT_TICK_CYC
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // binary inputs from pins
  input  wire        remote_receive_in,
  input  wire        channel_healthy_in,
  input  wire        timed_stage_block_in,
  input  wire        wi_block_in,
  input  wire        fuse_fail_in,
  input  wire        vt_breaker_in,
  input  wire [2:0]  phase_block_in,
  input  wire [2:0]  prot_pickup_in,
  input  wire [2:0]  ioc_pickup_in,
  // echo requests, same clock
  input  wire        dist_echo_req,
  input  wire        ef_echo_req,
  // measurements, same clock
  input  wire [15:0] vref_in,
  input  wire [15:0] upe_l1_in,
  input  wire [15:0] upe_l2_in,
  input  wire [15:0] upe_l3_in,
  input  wire [15:0] upp_l1_in,
  input  wire [15:0] upp_l2_in,
  input  wire [15:0] upp_l3_in,
  input  wire [15:0] residual_in,
  // decisions
  output reg  [2:0]  undervolt_out,
  output reg  [2:0]  pickup_out,
  output reg         general_pickup_out,
  output reg         multi_pickup_out,
  output reg  [2:0]  trip_pole_out,
  output reg         trip_three_out,
  output reg         residual_trip_out,
  output reg         general_trip_out,
  output reg         residual_alarm_flag,
  output reg         echo_dist_out,
  output reg         echo_ef_out,
  output reg         function_off_out,
  output reg         blocked_out
);

  // saturating increment shared by all delay counters, expiry test by all but res3_cnt
  function [15:0] inc;
    input [15:0] c;
    begin
      inc = (c == `WIT_INF) ? c : c + 16'h0001;
    end
  endfunction

  function tmo;
    input [15:0] c;
    input [15:0] s;
    begin
      tmo = (s != `WIT_INF) && (c >= s);
    end
  endfunction

  // settings
  reg  [8:0]  ctrl;
  reg  [6:0]  ratio;
  reg  [5:0]  tau;
  reg  [15:0] open_pole_level;
  reg  [15:0] residual_current_level;
  reg  [15:0] rx_ext_set;
  reg  [15:0] residual_stretch;
  reg  [15:0] residual_alarm_delay;
  reg  [15:0] single_pole_delay;
  reg  [15:0] multi_pole_delay;

  wire [1:0] function_mode_sel = ctrl[`WIT_F_MODE_HI:`WIT_F_MODE_LO];
  wire       shared_channel_echo = ctrl[`WIT_F_SHARED];
  wire       instant_stage_sel = ctrl[`WIT_F_INST];
  wire [1:0] timed_stage_sel = ctrl[`WIT_F_TSEL_HI:`WIT_F_TSEL_LO];
  wire       single_pole_allow = ctrl[`WIT_F_SP_ALLOW];
  wire       single_pole_need_residual = ctrl[`WIT_F_SP_RES];
  wire       three_pole_allow = ctrl[`WIT_F_TP_ALLOW];

  // pin synchronisers: three stages, value moves only when stages two and three agree
  localparam NIN = 15;
  wire [NIN-1:0] raw = {ioc_pickup_in, prot_pickup_in, phase_block_in, vt_breaker_in,
                        fuse_fail_in, wi_block_in, timed_stage_block_in,
                        channel_healthy_in, remote_receive_in};
  reg  [NIN-1:0] sy1;
  reg  [NIN-1:0] sy2;
  reg  [NIN-1:0] sy3;
  reg  [NIN-1:0] din;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= {NIN{1'b0}};
      sy2 <= {NIN{1'b0}};
      sy3 <= {NIN{1'b0}};
      din <= {NIN{1'b0}};
    end else begin
      sy1 <= raw;
      sy2 <= sy1;
      sy3 <= sy2;
      din <= (sy2 & sy3) | (din & (sy2 | sy3));
    end
  end

  wire       rx      = din[0];
  wire       ch_ok   = din[1];
  wire       t_blk   = din[2];
  wire       g_blk   = din[3];
  wire       v_fail  = din[4] | din[5];
  wire [2:0] ph_blk  = din[8:6];
  wire [2:0] prot_pk = din[11:9];
  wire [2:0] ioc_pk  = din[14:12];

  // millisecond tick
  reg [15:0] tick_cnt;
  reg        tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == TICK_CYC[15:0] - 16'h0001) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // threshold lag: a 1/1024 step every tau ticks gives about tau seconds
  reg  [25:0] filt;
  reg  [5:0]  tau_cnt;
  wire [25:0] xin = {vref_in, 10'h000};
  wire [22:0] prod = filt[25:10] * ratio;
  wire [22:0] quo = prod / `WIT_RATIO_DIV;
  wire [15:0] thr = quo[15:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt <= 26'h0000000;
      tau_cnt <= 6'h00;
    end else if (tick) begin
      if (tau_cnt + 6'h01 >= tau) begin
        tau_cnt <= 6'h00;
        if (xin >= filt)
          filt <= filt + ((xin - filt) >> `WIT_FILT_SHIFT);
        else
          filt <= filt - ((filt - xin) >> `WIT_FILT_SHIFT);
      end else begin
        tau_cnt <= tau_cnt + 6'h01;
      end
    end
  end

  // per-phase undervoltage
  wire [15:0] upe [0:2];
  wire [15:0] upp [0:2];
  assign upe[0] = upe_l1_in;
  assign upe[1] = upe_l2_in;
  assign upe[2] = upe_l3_in;
  assign upp[0] = upp_l1_in;
  assign upp[1] = upp_l2_in;
  assign upp[2] = upp_l3_in;

  reg [2:0] uv;
  integer k;
  always @* begin
    uv = 3'h0;
    for (k = 0; k < 3; k = k + 1)
      uv[k] = (upe[k] < thr)
              && (upp[k] >= open_pole_level)
              && !v_fail && !prot_pk[k];
  end

  // overcurrent lock-out latch, cleared by software; a new pickup wins over the clear
  reg  [2:0] lock;
  wire       wr = psel & penable & pready & pwrite;
  wire       lock_clr = wr && (paddr == `WIT_A_LATCH);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lock <= 3'h0;
    else
      lock <= ioc_pk | (lock & ~(lock_clr ? pwdata[2:0] : 3'h0));
  end

  // receive extension and residual timers
  reg  [15:0] rx_cnt;
  reg  [15:0] res_hold_cnt;
  reg  [15:0] res_alm_cnt;
  reg  [15:0] res3_cnt;
  wire        res_raw = residual_in > residual_current_level;
  wire        rx_ext = rx | !tmo(rx_cnt, rx_ext_set);
  wire        res_ext = res_raw | !tmo(res_hold_cnt, residual_stretch);
  wire        res_cond = rx_ext & ~|uv & res_ext;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= `WIT_INF;
      res_hold_cnt <= `WIT_INF;
      res_alm_cnt <= 16'h0000;
      res3_cnt <= 16'h0000;
    end else begin
      if (rx)
        rx_cnt <= 16'h0000;
      else if (tick)
        rx_cnt <= inc(rx_cnt);
      if (res_raw)
        res_hold_cnt <= 16'h0000;
      else if (tick)
        res_hold_cnt <= inc(res_hold_cnt);
      if (!res_raw)
        res_alm_cnt <= 16'h0000;
      else if (tick)
        res_alm_cnt <= inc(res_alm_cnt);
      if (!res_cond)
        res3_cnt <= 16'h0000;
      else if (tick)
        res3_cnt <= inc(res3_cnt);
    end
  end

  // stage enables
  wire trip_mode = (function_mode_sel == `WIT_MODE_TRIP) && !g_blk;
  wire inst_en = trip_mode && instant_stage_sel && ch_ok;
  // channel-failure choice runs the timed stage while the channel is not healthy
  wire tsel_ok = (timed_stage_sel == `WIT_TSEL_ON) ||
                 ((timed_stage_sel == `WIT_TSEL_RXFAIL) && !ch_ok);
  wire timed_en = trip_mode && tsel_ok && !t_blk;

  wire [2:0] inst_trip = {3{inst_en & rx_ext}} & uv & ~ph_blk & ~lock;
  wire       res_trip = inst_en && (res3_cnt > `WIT_RES3P_MS);
  wire [2:0] tpk = {3{timed_en}} & uv & ~lock;
  wire       one_pk = (tpk == 3'h1) || (tpk == 3'h2) || (tpk == 3'h4);
  wire       multi_pk = |tpk && !one_pk;

  // timed stage delays
  reg [15:0] sp_cnt;
  reg [15:0] mp_cnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_cnt <= 16'h0000;
      mp_cnt <= 16'h0000;
    end else begin
      if (!one_pk)
        sp_cnt <= 16'h0000;
      else if (tick)
        sp_cnt <= inc(sp_cnt);
      if (!multi_pk)
        mp_cnt <= 16'h0000;
      else if (tick)
        mp_cnt <= inc(mp_cnt);
    end
  end

  wire       sp_go = one_pk && tmo(sp_cnt, single_pole_delay) && single_pole_allow
                     && (!single_pole_need_residual || res_ext);
  wire       mp_go = multi_pk && tmo(mp_cnt, multi_pole_delay) && three_pole_allow;
  wire [2:0] next_pole = (inst_trip | (sp_go ? tpk : 3'h0)) & {3{!(mp_go | res_trip)}};
  wire       next_three = mp_go | res_trip;
  wire [2:0] next_pickup = inst_trip | tpk;

  // echo routing
  wire echo_on = (function_mode_sel != `WIT_MODE_OFF) && !g_blk;
  wire next_echo_d = echo_on && (dist_echo_req || (shared_channel_echo && ef_echo_req));
  wire next_echo_e = echo_on && ef_echo_req && !shared_channel_echo;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undervolt_out <= 3'h0;
      pickup_out <= 3'h0;
      general_pickup_out <= 1'b0;
      multi_pickup_out <= 1'b0;
      trip_pole_out <= 3'h0;
      trip_three_out <= 1'b0;
      residual_trip_out <= 1'b0;
      general_trip_out <= 1'b0;
      residual_alarm_flag <= 1'b0;
      echo_dist_out <= 1'b0;
      echo_ef_out <= 1'b0;
      function_off_out <= 1'b0;
      blocked_out <= 1'b0;
    end else begin
      undervolt_out <= uv;
      pickup_out <= next_pickup;
      general_pickup_out <= |next_pickup;
      multi_pickup_out <= multi_pk;
      trip_pole_out <= next_pole;
      trip_three_out <= next_three;
      residual_trip_out <= res_trip;
      general_trip_out <= |next_pole | next_three;
      residual_alarm_flag <= tmo(res_alm_cnt, residual_alarm_delay);
      echo_dist_out <= next_echo_d;
      echo_ef_out <= next_echo_e;
      function_off_out <= (function_mode_sel == `WIT_MODE_OFF);
      blocked_out <= g_blk;
    end
  end

  // apb: setup cycle prepares the answer, first access cycle completes it
  reg         hit;
  reg  [31:0] rd;
  always @* begin
    hit = 1'b1;
    rd = 32'h00000000;
    case (paddr)
      `WIT_A_CTRL:     rd[8:0] = ctrl;
      `WIT_A_RATIO:    rd[6:0] = ratio;
      `WIT_A_TAU:      rd[5:0] = tau;
      `WIT_A_OPENPOLE: rd[15:0] = open_pole_level;
      `WIT_A_RESLVL:   rd[15:0] = residual_current_level;
      `WIT_A_RXEXT:    rd[15:0] = rx_ext_set;
      `WIT_A_RESEXT:   rd[15:0] = residual_stretch;
      `WIT_A_RESALM:   rd[15:0] = residual_alarm_delay;
      `WIT_A_SPDLY:    rd[15:0] = single_pole_delay;
      `WIT_A_MPDLY:    rd[15:0] = multi_pole_delay;
      `WIT_A_STATUS:   rd[19:0] = {rx_ext, ch_ok, res_ext, residual_alarm_flag,
                                   multi_pickup_out, residual_trip_out, trip_three_out,
                                   general_trip_out, trip_pole_out, pickup_out,
                                   undervolt_out, lock};
      `WIT_A_LATCH:    rd[2:0] = lock;
      default:         hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata <= (psel & ~penable & ~pwrite) ? rd : 32'h00000000;
    end
  end

  // setting writes; out-of-range ratio and tau are clamped
  wire wr_ok = wr & ~pslverr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `WIT_RST_CTRL;
      ratio <= `WIT_RST_RATIO;
      tau <= `WIT_RST_TAU;
      open_pole_level <= `WIT_RST_OPEN;
      residual_current_level <= `WIT_RST_RESLVL;
      rx_ext_set <= `WIT_RST_RXEXT;
      residual_stretch <= `WIT_RST_RESEXT;
      residual_alarm_delay <= `WIT_RST_RESALM;
      single_pole_delay <= `WIT_RST_SPDLY;
      multi_pole_delay <= `WIT_RST_MPDLY;
    end else if (wr_ok) begin
      case (paddr)
        `WIT_A_CTRL:     ctrl <= pwdata[8:0];
        `WIT_A_RATIO: begin
          if (pwdata[31:0] < {25'h0, `WIT_RATIO_MIN})
            ratio <= `WIT_RATIO_MIN;
          else if (pwdata[31:0] > {25'h0, `WIT_RATIO_MAX})
            ratio <= `WIT_RATIO_MAX;
          else
            ratio <= pwdata[6:0];
        end
        `WIT_A_TAU: begin
          if (pwdata[31:0] < {26'h0, `WIT_TAU_MIN})
            tau <= `WIT_TAU_MIN;
          else if (pwdata[31:0] > {26'h0, `WIT_TAU_MAX})
            tau <= `WIT_TAU_MAX;
          else
            tau <= pwdata[5:0];
        end
        `WIT_A_OPENPOLE: open_pole_level <= pwdata[15:0];
        `WIT_A_RESLVL:   residual_current_level <= pwdata[15:0];
        `WIT_A_RXEXT:    rx_ext_set <= pwdata[15:0];
        `WIT_A_RESEXT:   residual_stretch <= pwdata[15:0];
        `WIT_A_RESALM:   residual_alarm_delay <= pwdata[15:0];
        `WIT_A_SPDLY:    single_pole_delay <= pwdata[15:0];
        `WIT_A_MPDLY:    multi_pole_delay <= pwdata[15:0];
        default:         ctrl <= ctrl;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** bench/wit_trip_properties.sv ***
// port assertions of the weak-infeed trip block
`timescale 1ns/10ps
`default_nettype none
module wit_trip_props (
  // apb
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins
  input wire logic       wi_block_in,
  input wire logic       fuse_fail_in,
  input wire logic       vt_breaker_in,
  // decisions
  input wire logic [2:0] undervolt_out,
  input wire logic [2:0] pickup_out,
  input wire logic       general_pickup_out,
  input wire logic [2:0] trip_pole_out,
  input wire logic       trip_three_out,
  input wire logic       residual_trip_out,
  input wire logic       general_trip_out,
  input wire logic       function_off_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h2C |=> pready && pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (psel && !penable && paddr <= 8'h2C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped access");
  gen_trip_or_a: assert property (general_trip_out == (|trip_pole_out || trip_three_out || residual_trip_out))
    else $error("general trip differs from its parts");
  gen_pick_or_a: assert property (general_pickup_out == |pickup_out)
    else $error("general pickup differs from its parts");
  block_quiet_a: assert property (wi_block_in [*6] |-> !general_trip_out && pickup_out == 3'h0)
    else $error("activity while blocked");
  vfail_uv_a: assert property ((fuse_fail_in || vt_breaker_in) [*6] |-> undervolt_out == 3'h0)
    else $error("undervoltage during voltage failure");
  off_quiet_a: assert property (function_off_out |-> !general_trip_out)
    else $error("trip while function off");
  three_over_a: assert property (trip_three_out |-> trip_pole_out == 3'h0)
    else $error("pole trip beside three-pole trip");
  cover property (trip_pole_out != 3'h0);
  cover property (residual_trip_out);
  cover property (pready && pslverr);
endmodule
bind wit_trip wit_trip_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .wi_block_in, .fuse_fail_in, .vt_breaker_in, .undervolt_out, .pickup_out, .general_pickup_out,
  .trip_pole_out, .trip_three_out, .residual_trip_out, .general_trip_out, .function_off_out);
`default_nettype wire

// *** bench/wit_channel_model.sv ***
// teleprotection receive channel model
`timescale 1ns/10ps
`default_nettype none
module wit_channel_model (
  // control from bench
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        rx_go,
  input wire logic [15:0] rx_wait,
  input wire logic [15:0] rx_len,
  input wire logic        link_ok,
  // relay binary inputs
  output logic            remote_receive_in,
  output logic            channel_healthy_in
);
  logic [15:0] wait_cnt;
  logic [15:0] len_cnt;
  // a restart drops the line during the wait, so a slow far end is seen as a gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 16'h0000;
      len_cnt <= 16'h0000;
    end else if (rx_go) begin
      wait_cnt <= rx_wait;
      len_cnt <= rx_len;
    end else if (wait_cnt != 16'h0000) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end else if (len_cnt != 16'h0000) begin
      len_cnt <= len_cnt - 16'h0001;
    end
  end
  assign remote_receive_in = wait_cnt == 16'h0000 && len_cnt != 16'h0000;
  assign channel_healthy_in = link_ok;
endmodule
`default_nettype wire

// *** bench/wit_trip_test.sv ***
// self-checking bench of the weak-infeed trip block
`timescale 1ns/10ps
`default_nettype none
`include "wit_map.vh"
module wit_trip_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv, rng;
  logic        rx_go, link_ok, remote_receive_in, channel_healthy_in;
  logic        tblk, wblk, ffail, vtb, gpick, mpick, t3, rtrip, gtrip, alarm, foff, inst, ok, b;
  logic [2:0]  pblk, ppick, ioc, uvm, opm, pb, pp, undervolt_out, pickup_out, trip_pole_out;
  logic [15:0] rx_wait, rx_len, vref, resid;
  logic [15:0] upe [3];
  logic [15:0] upp [3];
  logic [1:0]  mode;
  logic        de, ee, ed, eo, blk, sh;
  int          mismatches, total_checks;

  wit_trip #(.TICK_CYC(10)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .remote_receive_in, .channel_healthy_in, .timed_stage_block_in(tblk),
    .wi_block_in(wblk), .fuse_fail_in(ffail), .vt_breaker_in(vtb), .phase_block_in(pblk),
    .prot_pickup_in(ppick), .ioc_pickup_in(ioc), .dist_echo_req(de), .ef_echo_req(ee),
    .vref_in(vref), .upe_l1_in(upe[0]), .upe_l2_in(upe[1]), .upe_l3_in(upe[2]), .upp_l1_in(upp[0]),
    .upp_l2_in(upp[1]), .upp_l3_in(upp[2]), .residual_in(resid), .undervolt_out, .pickup_out,
    .general_pickup_out(gpick), .multi_pickup_out(mpick), .trip_pole_out, .trip_three_out(t3),
    .residual_trip_out(rtrip), .general_trip_out(gtrip), .residual_alarm_flag(alarm),
    .echo_dist_out(ed), .echo_ef_out(eo), .function_off_out(foff), .blocked_out(blk));
  wit_channel_model CH (.pclk, .presetn, .rx_go, .rx_wait, .rx_len, .link_ok, .remote_receive_in,
    .channel_healthy_in);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] exp_pick(input logic [1:0] m, input logic i, k, bl,
                                          input logic [2:0] u, o, pbl, ppk);
    return (m == `WIT_MODE_TRIP && i && k && !bl) ? (u & ~o & ~pbl & ~ppk) : 3'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // request held until the edge that samples pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdv = prdata;
    err = pslverr;
    chk("pready", 32'h1, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, rdv);
  endtask
  task automatic volts(input logic [2:0] u, o);
    for (int k = 0; k < 3; k++) begin
      upe[k] <= u[k] ? 16'h0010 : 16'hF000;
      upp[k] <= o[k] ? 16'h0080 : 16'h1000;
    end
  endtask
  task automatic rx(input logic [15:0] w, l);
    rx_go <= 1'b1;
    rx_wait <= w;
    rx_len <= l;
    @(posedge pclk);
    rx_go <= 1'b0;
  endtask
  task automatic conclude;
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    wt(30000);
    mismatches++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, rx_go, rx_wait, rx_len, resid} = '0;
    {tblk, wblk, ffail, vtb, pblk, ppick, ioc, de, ee} = '0;
    {mismatches, total_checks} = '0;
    link_ok = 1'b1;
    vref = 16'h8000;
    rng = 32'h3E15;
    for (int k = 0; k < 3; k++) {upe[k], upp[k]} = {16'hF000, 16'h1000};
    presetn = 1'b0;
    wt(3);
    presetn <= 1'b1;
    wt(1);
    rdc(`WIT_A_CTRL, `WIT_RST_CTRL);
    rdc(`WIT_A_RATIO, `WIT_RST_RATIO);
    rdc(`WIT_A_TAU, `WIT_RST_TAU);
    rdc(`WIT_A_RXEXT, `WIT_RST_RXEXT);
    rdc(`WIT_A_RESEXT, `WIT_RST_RESEXT);
    rdc(`WIT_A_RESALM, `WIT_RST_RESALM);
    rdc(`WIT_A_SPDLY, `WIT_RST_SPDLY);
    rdc(`WIT_A_MPDLY, `WIT_RST_MPDLY);
    rdc(8'h30, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    apb(1'b1, `WIT_A_RATIO, 32'h5);
    rdc(`WIT_A_RATIO, `WIT_RATIO_MIN);
    apb(1'b1, `WIT_A_RATIO, 32'h65);
    rdc(`WIT_A_RATIO, `WIT_RATIO_MAX);
    apb(1'b1, `WIT_A_RATIO, `WIT_RST_RATIO);
    // the lagged threshold starts at zero and needs time to rise
    wt(500);
    rx(16'h0, 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      rng = lfsr(rng);
      mode = (rng[1:0] == 2'h3) ? `WIT_MODE_TRIP : rng[1:0];
      {inst, ok, b} = {rng[2], rng[3] | rng[7], rng[4] & rng[5]};
      {uvm, opm} = {rng[10:8], rng[13:11] & rng[16:14]};
      {pb, pp} = {rng[19:17] & rng[22:20], rng[25:23] & rng[28:26]};
      sh = rng[31];
      {link_ok, wblk, pblk, ppick, de, ee} <= {ok, b, pb, pp, rng[30:29]};
      volts(uvm, opm);
      apb(1'b1, `WIT_A_CTRL, {23'h0, 9'h1C0 | {5'h0, inst, sh, mode}});
      wt(12);
      chk("pickup", 32'(exp_pick(mode, inst, ok, b, uvm, opm, pb, pp)), 32'(pickup_out));
      chk("trip", 32'(|exp_pick(mode, inst, ok, b, uvm, opm, pb, pp)), 32'(gtrip));
      chk("off", 32'(mode == `WIT_MODE_OFF), 32'(foff));
      chk("gpick", 32'(|exp_pick(mode, inst, ok, b, uvm, opm, pb, pp)), 32'(gpick));
      chk("blocked", 32'(b), 32'(blk));
      chk("echo_dist", 32'(mode != `WIT_MODE_OFF && !b && (de || (sh && ee))), 32'(ed));
      chk("echo_ef", 32'(mode != `WIT_MODE_OFF && !b && ee && !sh), 32'(eo));
      if (pp == 3'h0 && !b && mode == `WIT_MODE_TRIP)
        chk("uv", 32'(uvm & ~opm), 32'(undervolt_out));
    end
    {link_ok, wblk, pblk, ppick, ffail} <= {1'b1, 1'b0, 3'h0, 3'h0, 1'b1};
    volts(3'h7, 3'h0);
    wt(12);
    chk("uv", 32'h0, 32'(undervolt_out));
    {ffail, vtb} <= 2'b01;
    wt(12);
    chk("uv", 32'h0, 32'(undervolt_out));
    vtb <= 1'b0;
    apb(1'b1, `WIT_A_CTRL, 32'h1CA);
    apb(1'b1, `WIT_A_RXEXT, 32'd20);
    volts(3'h1, 3'h0);
    rx(16'd3, 16'd5);
    wt(150);
    chk("pickup", 32'h1, 32'(pickup_out));
    wt(150);
    chk("pickup", 32'h0, 32'(pickup_out));
    rx(16'h0, 16'hFFFF);
    ioc <= 3'h1;
    wt(10);
    ioc <= 3'h0;
    wt(12);
    chk("pickup", 32'h0, 32'(pickup_out));
    rdc(`WIT_A_LATCH, 32'h1);
    apb(1'b1, `WIT_A_LATCH, 32'h1);
    wt(12);
    chk("pickup", 32'h1, 32'(pickup_out));
    volts(3'h0, 3'h0);
    apb(1'b1, `WIT_A_RESEXT, 32'd20);
    apb(1'b1, `WIT_A_RESALM, 32'd300);
    resid <= 16'h0300;
    wt(2900);
    chk("alarm", 32'h0, 32'(alarm));
    wt(200);
    chk("alarm", 32'h1, 32'(alarm));
    wt(1800);
    chk("restrip", 32'h0, 32'(rtrip));
    wt(200);
    chk("restrip", 32'h1, 32'(rtrip));
    chk("trip", 32'h1, 32'(gtrip));
    resid <= 16'h0000;
    wt(100);
    chk("restrip", 32'h1, 32'(rtrip));
    wt(200);
    chk("restrip", 32'h0, 32'(rtrip));
    rx(16'h0, 16'h0);
    apb(1'b1, `WIT_A_SPDLY, 32'd40);
    for (int j = 0; j < 3; j++) begin
      volts(3'h0, 3'h0);
      tblk <= (j == 2);
      apb(1'b1, `WIT_A_CTRL, (j == 1) ? 32'h112 : 32'h152);
      wt(20);
      volts(3'h1, 3'h0);
      wt(380);
      chk("pole", 32'h0, 32'(trip_pole_out));
      wt(60);
      chk("pole", (j == 0) ? 32'h1 : 32'h0, 32'(trip_pole_out));
    end
    tblk <= 1'b0;
    apb(1'b1, `WIT_A_MPDLY, 32'd30);
    apb(1'b1, `WIT_A_CTRL, 32'h052);
    volts(3'h3, 3'h0);
    wt(400);
    chk("multi", 32'h1, 32'(mpick));
    chk("three", 32'h0, 32'(t3));
    apb(1'b1, `WIT_A_CTRL, 32'h152);
    wt(4);
    chk("three", 32'h1, 32'(t3));
    conclude();
  end
endmodule
`default_nettype wire
